/* File: pps_defines.svh */
// register offsets, field positions, reset values and hold counts for the slave buffer block
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

// register byte offsets
`define PPS_STATUS_OFS     8'h00
`define PPS_MODE_OFS       8'h04
`define PPS_ADDR_OFS       8'h08
`define PPS_IRQ_STAT_OFS   8'h0c
`define PPS_IRQ_MASK_OFS   8'h10
// buffer windows: haddr[7:4] selects the page, haddr[3:2] the slot
`define PPS_IN_BUF_PAGE    4'h2
`define PPS_OUT_BUF_PAGE   4'h3

// slave_buffer_status bit positions
`define PPS_ST_IN_ALL_FULL    15
`define PPS_ST_IN_OVERFLOW    14
`define PPS_ST_IN_SLOT_LSB    8
`define PPS_ST_OUT_ALL_EMPTY  7
`define PPS_ST_OUT_UNDERFLOW  6
`define PPS_ST_OUT_SLOT_LSB   0
`define PPS_ST_RSVD_MASK      32'hffff_3030

// port_mode_config fields
`define PPS_MD_END_LSB     0
`define PPS_MD_MID_LSB     2
`define PPS_MD_BEG_LSB     6
`define PPS_MD_SLAVE_EN    8
`define PPS_MD_CS2_EN      9
`define PPS_MD_STEP_LSB    10
`define PPS_MODE_RST       12'h000
`define PPS_OUT_EMPTY_RST  4'hf
`define PPS_ADDR_CS2_BIT   14

// interrupt status and mask bits
`define PPS_IRQ_OVF        0
`define PPS_IRQ_UNF        1
`define PPS_IRQ_HOST_WR    2
`define PPS_IRQ_HOST_RD    3

// strobe timing, in peripheral clock periods
`define PPS_WR_HOLD_BASE   3'h1
`define PPS_BEGIN_BASE     3'h1
`define PPS_FORCED_WR      3'h1
`define PPS_FORCED_RD_BEG  3'h1
`define PPS_FORCED_RD_END  3'h0

`endif

/* File: pps_pkg.sv */
// types shared by the slave buffer block
`include "pps_defines.svh"
package pps_pkg;

   // host strobe sequencer
   typedef enum logic [2:0] {
      PPS_IDLE    = 3'b000,
      PPS_SETUP   = 3'b001,
      PPS_DRIVE   = 3'b010,
      PPS_HOLD_RD = 3'b011,
      PPS_HOLD_WR = 3'b100
   } pps_phase_t;

   // pins from the external parallel host
   typedef struct packed {
      logic       cs;
      logic       wr;
      logic       rd;
      logic [1:0] addr;
      logic [7:0] din;
   } pps_host_in_t;

   // pins toward the external parallel host
   typedef struct packed {
      logic [7:0] dout;
      logic       dout_oe;
      logic       busy;
   } pps_host_out_t;

   // whole state of the block
   typedef struct packed {
      logic [3:0]  in_full;
      logic [31:0] in_data;
      logic [3:0]  out_empty;
      logic [31:0] out_data;
      logic        ovf;
      logic        unf;
      logic [11:0] mode;
      logic [15:0] addr;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      pps_phase_t  phase;
      logic [2:0]  cnt;
      logic        wr_prev;
      logic        rd_prev;
      logic        dp_valid;
      logic        dp_write;
      logic [7:0]  dp_addr;
      logic [31:0] rdata;
      logic [7:0]  dout;
      logic        dout_oe;
   } pps_state_t;

endpackage

/* File: pps_slave_buffers.sv */
// slave-mode buffered parallel port: byte buffers, status flags, strobe hold timing, ahb-lite registers
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "pps_defines.svh"
module pps_slave_buffers (
   // clock and reset
   input  wire logic                    hclk,
   input  wire logic                    hresetn,
   // ahb-lite slave
   input  wire logic                    hsel,
   input  wire logic [7:0]              haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output      logic                    hreadyout,
   output      logic                    hresp,
   output      logic [31:0]             hrdata,
   // parallel host pins
   input  wire pps_pkg::pps_host_in_t   host_in,
   output      pps_pkg::pps_host_out_t  host_out,
   // interrupt
   output      logic                    irq
);

   localparam pps_pkg::pps_state_t STATE_RST = '{
      out_empty : `PPS_OUT_EMPTY_RST,
      mode      : `PPS_MODE_RST,
      phase     : pps_pkg::PPS_IDLE,
      default   : '0
   };

   pps_pkg::pps_state_t s;
   pps_pkg::pps_state_t next_s;
   logic                sw_acc;
   logic                sw_rd;
   logic                slave_on;
   logic                wr_rise;
   logic                wr_fall;
   logic                rd_rise;
   logic                rd_fall;
   logic                host_wr_acc;
   logic                host_rd_acc;
   logic                dp_wr;

   // hold after the strobe ends; forced defaults when the middle width is zero
   function automatic logic [2:0] hold_periods(input logic [11:0] md, input logic is_wr);
      logic [2:0] code;
      code = {1'b0, md[`PPS_MD_END_LSB +: 2]};
      if (md[`PPS_MD_MID_LSB +: 4] == 4'h0)
         hold_periods = is_wr ? `PPS_FORCED_WR : `PPS_FORCED_RD_END;
      else
         hold_periods = is_wr ? code + `PPS_WR_HOLD_BASE : code;
   endfunction

   // address step after a completed host access
   function automatic logic [15:0] step_addr(input logic [11:0] md, input logic [15:0] a);
      logic [15:0] r;
      case (md[`PPS_MD_STEP_LSB +: 2])
         2'b01: r = a + 16'h0001;
         2'b10: r = a - 16'h0001;
         default: r = a;
      endcase
      if (md[`PPS_MD_CS2_EN])
         r[`PPS_ADDR_CS2_BIT] = a[`PPS_ADDR_CS2_BIT];
      step_addr = r;
   endfunction

   // status word assembly
   function automatic logic [31:0] status_word(input pps_pkg::pps_state_t st);
      status_word = 32'h0000_0000;
      status_word[`PPS_ST_IN_ALL_FULL] = &st.in_full;
      status_word[`PPS_ST_IN_OVERFLOW] = st.ovf;
      status_word[`PPS_ST_IN_SLOT_LSB +: 4] = st.in_full;
      status_word[`PPS_ST_OUT_ALL_EMPTY] = &st.out_empty;
      status_word[`PPS_ST_OUT_UNDERFLOW] = st.unf;
      status_word[`PPS_ST_OUT_SLOT_LSB +: 4] = st.out_empty;
   endfunction

   // bus and strobe decode
   assign sw_acc      = hsel && htrans[1] && hready && (hsize == 3'h2);
   assign sw_rd       = sw_acc && !hwrite;
   assign dp_wr       = s.dp_valid && s.dp_write;
   assign slave_on    = s.mode[`PPS_MD_SLAVE_EN];
   assign wr_rise     = host_in.wr && !s.wr_prev;
   assign wr_fall     = !host_in.wr && s.wr_prev;
   assign rd_rise     = host_in.rd && !s.rd_prev;
   assign rd_fall     = !host_in.rd && s.rd_prev;
   // buffers respond only in slave mode
   assign host_wr_acc = slave_on && host_in.cs && wr_rise && (s.phase == pps_pkg::PPS_IDLE);
   assign host_rd_acc = slave_on && host_in.cs && rd_rise && !wr_rise && (s.phase == pps_pkg::PPS_IDLE);

   // next state: software effects first, host effects after so hardware sets win
   always_comb begin
      next_s          = s;
      next_s.wr_prev  = host_in.wr;
      next_s.rd_prev  = host_in.rd;

      // data phase of a software write
      if (dp_wr) begin
         case (s.dp_addr)
            `PPS_MODE_OFS: begin
               next_s.mode = hwdata[11:0];
            end
            `PPS_ADDR_OFS: begin
               next_s.addr = hwdata[15:0];
            end
            `PPS_STATUS_OFS: begin
               if (hwdata[`PPS_ST_IN_OVERFLOW])
                  next_s.ovf = 1'b0;
               if (hwdata[`PPS_ST_OUT_UNDERFLOW])
                  next_s.unf = 1'b0;
            end
            `PPS_IRQ_STAT_OFS: begin
               next_s.irq_stat = s.irq_stat & ~hwdata[3:0];
            end
            `PPS_IRQ_MASK_OFS: begin
               next_s.irq_mask = hwdata[3:0];
            end
            default: begin
               if (s.dp_addr[7:4] == `PPS_OUT_BUF_PAGE) begin
                  next_s.out_data[8*s.dp_addr[3:2] +: 8] = hwdata[7:0];
                  next_s.out_empty[s.dp_addr[3:2]]       = 1'b0;
               end
            end
         endcase
      end

      // address phase; read data is captured here so hrdata comes from a flop
      next_s.dp_valid = sw_acc;
      next_s.dp_write = hwrite;
      next_s.dp_addr  = haddr;
      if (sw_rd) begin
         case (haddr)
            `PPS_STATUS_OFS:   next_s.rdata = status_word(s);
            `PPS_MODE_OFS:     next_s.rdata = {20'h0_0000, s.mode};
            `PPS_ADDR_OFS:     next_s.rdata = {16'h0000, s.addr};
            `PPS_IRQ_STAT_OFS: next_s.rdata = {28'h000_0000, s.irq_stat};
            `PPS_IRQ_MASK_OFS: next_s.rdata = {28'h000_0000, s.irq_mask};
            default: begin
               next_s.rdata = 32'h0000_0000;
               if (haddr[7:4] == `PPS_IN_BUF_PAGE) begin
                  next_s.rdata = {24'h00_0000, s.in_data[8*haddr[3:2] +: 8]};
                  next_s.in_full[haddr[3:2]] = 1'b0;
               end else if (haddr[7:4] == `PPS_OUT_BUF_PAGE) begin
                  next_s.rdata = {24'h00_0000, s.out_data[8*haddr[3:2] +: 8]};
               end
            end
         endcase
      end

      // host strobe sequencer
      case (s.phase)
         pps_pkg::PPS_IDLE: begin
            // strobe rises and the write fall are only looked for while idle
            if (host_wr_acc) begin
               if (s.in_full[host_in.addr]) begin
                  next_s.ovf                  = 1'b1;
                  next_s.irq_stat[`PPS_IRQ_OVF] = 1'b1;
               end else begin
                  next_s.in_data[8*host_in.addr +: 8] = host_in.din;
                  next_s.in_full[host_in.addr]        = 1'b1;
                  next_s.irq_stat[`PPS_IRQ_HOST_WR]   = 1'b1;
               end
            end else if (host_rd_acc) begin
               if (s.out_empty[host_in.addr]) begin
                  next_s.unf                    = 1'b1;
                  next_s.irq_stat[`PPS_IRQ_UNF] = 1'b1;
               end else begin
                  next_s.dout                       = s.out_data[8*host_in.addr +: 8];
                  next_s.out_empty[host_in.addr]    = 1'b1;
                  next_s.irq_stat[`PPS_IRQ_HOST_RD] = 1'b1;
                  next_s.phase                      = pps_pkg::PPS_SETUP;
                  if (s.mode[`PPS_MD_MID_LSB +: 4] == 4'h0)
                     next_s.cnt = `PPS_FORCED_RD_BEG - 3'h1;
                  else
                     next_s.cnt = {1'b0, s.mode[`PPS_MD_BEG_LSB +: 2]} + `PPS_BEGIN_BASE - 3'h1;
               end
            end else if (wr_fall && slave_on) begin
               next_s.addr  = step_addr(s.mode, s.addr);
               next_s.cnt   = hold_periods(s.mode, 1'b1) - 3'h1;
               next_s.phase = pps_pkg::PPS_HOLD_WR;
            end
         end
         pps_pkg::PPS_SETUP: begin
            if (!host_in.rd) begin
               next_s.phase = pps_pkg::PPS_IDLE;
            end else if (s.cnt == 3'h0) begin
               next_s.dout_oe = 1'b1;
               next_s.phase   = pps_pkg::PPS_DRIVE;
            end else begin
               next_s.cnt = s.cnt - 3'h1;
            end
         end
         pps_pkg::PPS_DRIVE: begin
            if (rd_fall) begin
               next_s.addr = step_addr(s.mode, s.addr);
               // read hold, zero drops at once
               if (hold_periods(s.mode, 1'b0) == 3'h0) begin
                  next_s.dout_oe = 1'b0;
                  next_s.phase   = pps_pkg::PPS_IDLE;
               end else begin
                  next_s.cnt   = hold_periods(s.mode, 1'b0) - 3'h1;
                  next_s.phase = pps_pkg::PPS_HOLD_RD;
               end
            end
         end
         pps_pkg::PPS_HOLD_RD: begin
            if (s.cnt == 3'h0) begin
               next_s.dout_oe = 1'b0;
               next_s.phase   = pps_pkg::PPS_IDLE;
            end else begin
               next_s.cnt = s.cnt - 3'h1;
            end
         end
         pps_pkg::PPS_HOLD_WR: begin
            if (s.cnt == 3'h0)
               next_s.phase = pps_pkg::PPS_IDLE;
            else
               next_s.cnt = s.cnt - 3'h1;
         end
         default: begin
            next_s.dout_oe = 1'b0;
            next_s.phase   = pps_pkg::PPS_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         s <= STATE_RST;
      else
         s <= next_s;
   end

   // outputs; zero-wait slave, always okay
   assign hreadyout        = 1'b1;
   assign hresp            = 1'b0;
   assign hrdata           = s.rdata;
   assign host_out.dout    = s.dout;
   assign host_out.dout_oe = s.dout_oe;
   // busy keeps the host off while setup, read hold or write hold runs
   assign host_out.busy    = (s.phase == pps_pkg::PPS_SETUP) || (s.phase == pps_pkg::PPS_HOLD_WR)
                             || (s.phase == pps_pkg::PPS_HOLD_RD);
   assign irq              = |(s.irq_stat & s.irq_mask);

   // checks
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);

   all_full_a: assert property (sw_rd && haddr == `PPS_STATUS_OFS |=> hrdata[15] == $past(&s.in_full))
      else $error("input all-full flag wrong");
   ovf_set_a: assert property (host_wr_acc && s.in_full[host_in.addr] |=> s.ovf)
      else $error("overflow not set");
   ovf_sticky_a: assert property (s.ovf && !(dp_wr && s.dp_addr == `PPS_STATUS_OFS && hwdata[14]) |=> s.ovf)
      else $error("overflow cleared by hardware");
   slot_clear_a: assert property (sw_rd && haddr[7:4] == `PPS_IN_BUF_PAGE && !host_wr_acc
                                  |=> !s.in_full[$past(haddr[3:2])])
      else $error("input slot full not cleared");
   all_empty_a: assert property (sw_rd && haddr == `PPS_STATUS_OFS |=> hrdata[7] == $past(&s.out_empty))
      else $error("output all-empty flag wrong");
   unf_set_a: assert property (host_rd_acc && s.out_empty[host_in.addr] |=> s.unf)
      else $error("underflow not set");
   slot_fill_a: assert property (dp_wr && s.dp_addr[7:4] == `PPS_OUT_BUF_PAGE && !host_rd_acc
                                 |=> !s.out_empty[$past(s.dp_addr[3:2])])
      else $error("output slot empty not cleared");
   wr_hold_a: assert property (s.phase == pps_pkg::PPS_IDLE && wr_fall && slave_on && !host_wr_acc
                               && s.mode[5:0] == 6'h07 |=> host_out.busy [*4] ##1 !host_out.busy)
      else $error("write hold not four periods");
   rd_hold_a: assert property (s.phase == pps_pkg::PPS_DRIVE && rd_fall && s.mode[5:0] == 6'h07
                               |=> s.dout_oe [*3] ##1 !s.dout_oe)
      else $error("read hold not three periods");
   rd_forced_a: assert property (s.phase == pps_pkg::PPS_DRIVE && rd_fall && s.mode[5:2] == 4'h0
                                 |=> !s.dout_oe)
      else $error("forced read hold not zero");
   cs2_keep_a: assert property (s.mode[`PPS_MD_CS2_EN] && !(dp_wr && s.dp_addr == `PPS_ADDR_OFS)
                                |=> s.addr[14] == $past(s.addr[14]))
      else $error("chip select address bit stepped");
   slave_only_a: assert property (!slave_on |=> !$rose(s.ovf) && !$rose(s.unf))
      else $error("flag raised outside slave mode");
   rsvd_zero_a: assert property (sw_rd && haddr == `PPS_STATUS_OFS
                                 |=> (hrdata & `PPS_ST_RSVD_MASK) == 32'h0000_0000)
      else $error("reserved status bit set");

endmodule // pps_slave_buffers

/* File: pps_host_model.sv */
// behavioural parallel host that drives the block's strobe pins
`timescale 1ns/1ps
module pps_host_model (
   // clock
   input  wire logic                    hclk,
   // pins toward and from the block
   output      pps_pkg::pps_host_in_t   host_in,
   input  wire pps_pkg::pps_host_out_t  host_out
);
   // pins idle low from time zero, so no strobe edge is seen at reset release
   initial host_in = '0;

   // one byte per strobe, then wait out the whole hold
   task automatic host_write(input logic [1:0] s, input logic [7:0] d, output int h);
      h = 0;
      @(posedge hclk);
      host_in.cs <= 1'b1;
      host_in.wr <= 1'b1;
      host_in.addr <= s;
      host_in.din <= d;
      @(posedge hclk);
      host_in.wr <= 1'b0;
      host_in.cs <= 1'b0;
      // released data line shows the inverse, not a stale byte
      host_in.din <= ~d;
      repeat (10) begin
         @(posedge hclk);
         #1 h += int'(host_out.busy === 1'b1);
      end
   endtask

   // strobed read; b counts edges until data is driven, r the hold after release
   task automatic host_read(input logic [1:0] s, output logic [7:0] d, output int b, output int r);
      b = 0;
      r = 0;
      d = 8'h00;
      @(posedge hclk);
      host_in.cs <= 1'b1;
      host_in.rd <= 1'b1;
      host_in.addr <= s;
      // bounded wait: an empty slot never drives the pins
      while (b < 8 && host_out.dout_oe !== 1'b1) begin
         @(posedge hclk);
         #1 b++;
      end
      if (host_out.dout_oe === 1'b1) d = host_out.dout;
      @(posedge hclk);
      host_in.rd <= 1'b0;
      host_in.cs <= 1'b0;
      repeat (8) begin
         @(posedge hclk);
         #1 r += int'(host_out.dout_oe === 1'b1);
      end
   endtask
endmodule // pps_host_model

/* File: pps_slave_buffers_bench.sv */
// self-checking testbench for the slave buffer block
`timescale 1ns/1ps
`include "pps_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, g, e); end end
module pps_slave_buffers_bench;
   logic                    hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [7:0]              haddr, d;
   logic [1:0]              htrans;
   logic [2:0]              hsize;
   logic [31:0]             hwdata, hrdata, v;
   wire logic               hready;
   pps_pkg::pps_host_in_t   host_in;
   pps_pkg::pps_host_out_t  host_out;
   int                      bad_count, n_tests, h, b, r;

   // one slave, so its ready is the bus ready
   assign hready = hreadyout;

   pps_slave_buffers dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .host_in(host_in), .host_out(host_out), .irq(irq));
   pps_host_model host (.hclk(hclk), .host_in(host_in), .host_out(host_out));

   // 20 MHz clock
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // single word transfer; waits on ready, never assumes a latency
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      v = hrdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      `CHK(v, e)
      // zero-wait, always okay: ready high and no error response
      `CHK({hreadyout, hresp}, 2'b10)
   endtask

   // reset values, reserved bits, unmapped place, host ignored outside slave mode
   task automatic t_reset();
      rd_chk(`PPS_STATUS_OFS, 32'h0000_008f);
      rd_chk(`PPS_MODE_OFS, 32'h0);
      rd_chk(8'h44, 32'h0);
      ahb(1'b1, `PPS_STATUS_OFS, 32'hffff_ffff);
      rd_chk(`PPS_STATUS_OFS, 32'h0000_008f);
      host.host_write(2'd0, 8'h5a, h);
      rd_chk(`PPS_STATUS_OFS, 32'h0000_008f);
   endtask

   // fill every input slot, overflow one, interrupt path, drain
   task automatic t_input();
      ahb(1'b1, `PPS_MODE_OFS, 32'h104);
      ahb(1'b1, `PPS_IRQ_STAT_OFS, 32'hf);
      for (int i = 0; i < 4; i++) begin
         host.host_write(2'(i), 8'ha0 + 8'(i), h);
         rd_chk(`PPS_STATUS_OFS, 32'h8f | ((32'h1 << (i + 9)) - 32'h100) | (i == 3 ? 32'h8000 : 0));
      end
      host.host_write(2'd2, 8'h77, h);
      rd_chk(`PPS_STATUS_OFS, 32'h0000_cf8f);
      rd_chk(`PPS_IRQ_STAT_OFS, 32'h5);
      #1 `CHK(irq, 1'b0)
      ahb(1'b1, `PPS_IRQ_MASK_OFS, 32'h1);
      #1 `CHK(irq, 1'b1)
      ahb(1'b1, `PPS_IRQ_STAT_OFS, 32'h1);
      #1 `CHK(irq, 1'b0)
      // dropped byte must not replace the stored one
      rd_chk({`PPS_IN_BUF_PAGE, 4'h8}, 32'ha2);
      rd_chk(`PPS_STATUS_OFS, 32'h0000_4b8f);
      ahb(1'b1, `PPS_STATUS_OFS, 32'h4000);
      rd_chk(`PPS_STATUS_OFS, 32'h0000_0b8f);
      for (int i = 0; i < 4; i++) ahb(1'b0, {`PPS_IN_BUF_PAGE, 2'(i), 2'b00}, 32'h0);
      rd_chk(`PPS_STATUS_OFS, 32'h0000_008f);
   endtask

   // load every output slot, host takes them, then reads an empty one
   task automatic t_output();
      ahb(1'b1, `PPS_IRQ_STAT_OFS, 32'hf);
      for (int i = 0; i < 4; i++) ahb(1'b1, {`PPS_OUT_BUF_PAGE, 2'(i), 2'b00}, 32'h10 + i);
      rd_chk(`PPS_STATUS_OFS, 32'h0);
      host.host_read(2'd1, d, b, r);
      `CHK(d, 8'h11)
      rd_chk(`PPS_STATUS_OFS, 32'h2);
      for (int i = 0; i < 4; i++) if (i != 1) host.host_read(2'(i), d, b, r);
      rd_chk(`PPS_STATUS_OFS, 32'h8f);
      host.host_read(2'd1, d, b, r);
      `CHK(b, 8)
      rd_chk(`PPS_STATUS_OFS, 32'hcf);
      rd_chk(`PPS_IRQ_STAT_OFS, 32'ha);
      ahb(1'b1, `PPS_IRQ_MASK_OFS, 32'h2);
      #1 `CHK(irq, 1'b1)
      ahb(1'b1, `PPS_STATUS_OFS, 32'h40);
      rd_chk(`PPS_STATUS_OFS, 32'h8f);
      ahb(1'b1, `PPS_IRQ_MASK_OFS, 32'h0);
   endtask

   // every hold code; pass 4 uses a zero middle width with the largest codes
   task automatic t_timing();
      for (int c = 0; c < 5; c++) begin
         ahb(1'b1, `PPS_MODE_OFS, c < 4 ? 32'h104 | 32'(c) | 32'(c << 6) : 32'h1c3);
         host.host_write(2'd0, 8'(c), h);
         `CHK(h, c < 4 ? c + 1 : 1)
         rd_chk({`PPS_IN_BUF_PAGE, 4'h0}, 32'(c));
         ahb(1'b1, {`PPS_OUT_BUF_PAGE, 4'h0}, 32'h3c + c);
         host.host_read(2'd0, d, b, r);
         `CHK(d, 8'(32'h3c + c))
         `CHK(b, c < 4 ? c + 2 : 2)
         `CHK(r, c < 4 ? c : 0)
      end
   endtask

   // address stepping with and without the second chip select
   task automatic t_addr();
      ahb(1'b1, `PPS_MODE_OFS, 32'h504);
      ahb(1'b1, `PPS_ADDR_OFS, 32'h3fff);
      host.host_write(2'd1, 8'h01, h);
      rd_chk(`PPS_ADDR_OFS, 32'h4000);
      ahb(1'b1, `PPS_MODE_OFS, 32'h704);
      ahb(1'b1, `PPS_ADDR_OFS, 32'h7fff);
      host.host_write(2'd2, 8'h02, h);
      rd_chk(`PPS_ADDR_OFS, 32'hc000);
      // decrement across the held bit: it stays set, lower bits borrow
      ahb(1'b1, `PPS_MODE_OFS, 32'hb04);
      ahb(1'b1, `PPS_ADDR_OFS, 32'h4000);
      host.host_write(2'd3, 8'h03, h);
      rd_chk(`PPS_ADDR_OFS, 32'h7fff);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // main sequence: reset for 4 cycles, then the scenarios
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      bad_count = 0;
      n_tests = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_input();
      t_output();
      t_timing();
      t_addr();
      print_verdict();
   end

   // watchdog, well beyond the roughly 500 cycles the scenarios need
   initial begin
      repeat (6000) @(posedge hclk);
      bad_count++;
      print_verdict();
   end
endmodule // pps_slave_buffers_bench
